// >>> hdl/frc_map.svh
`ifndef FRC_MAP_SVH
`define FRC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FRC_ADDR_NV 4'h0
`define FRC_ADDR_V 4'h1
`define FRC_ADDR_CTRL 4'h2
`define FRC_ADDR_STAT 4'h3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FRC_IMP_HI 7
`define FRC_IMP_LO 5
`define FRC_WEN_BIT 4
`define FRC_ECC_BIT 3
`define FRC_PDS_BIT 2
`define FRC_WL_HI 1
`define FRC_WL_LO 0
// ----------------------------------------
// Reset value and volatile write mask
// ----------------------------------------
`define FRC_NV_RESET 8'h08
`define FRC_WRITABLE_V 8'hFB
`endif

// >>> hdl/frc_pkg.sv
package frc_pkg;
    typedef enum logic [2:0] {
        FRC_ST_LOAD = 3'b001,
        FRC_ST_STANDBY = 3'b010,
        FRC_ST_DPD = 3'b100
    } frc_state_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } frc_bus_type;

    typedef struct packed {
        logic [2:0] impedance;
        logic wrap_en;
        logic ecc_dbl;
        logic [1:0] wrap_len;
    } frc_cfg_type;
endpackage : frc_pkg

// >>> hdl/frc_wrap_addr.sv
`timescale 1ns/10ps
module frc_wrap_addr (
    input wire logic [31:0] i_addr, // Current read address
    input wire logic i_wrap_en, // Wrapped mode
    input wire logic [1:0] i_wrap_len, // Length code
    output logic [31:0] o_next, // Next address
    output logic [6:0] o_len_bytes // Decoded length
);
    logic [5:0] mask;
    logic [5:0] low_inc;

    always_comb begin
        unique case (i_wrap_len)
            2'b00: mask = 6'h07;
            2'b01: mask = 6'h0F;
            2'b10: mask = 6'h1F;
            2'b11: mask = 6'h3F;
        endcase
        o_len_bytes = {1'b0, mask} + 7'h01;
        low_inc = i_addr[5:0] + 6'h01;
        if (i_wrap_en) begin
            o_next = {i_addr[31:6], (i_addr[5:0] & ~mask) | (low_inc & mask)};
        end else begin
            o_next = i_addr + 32'h0000_0001;
        end
    end
endmodule : frc_wrap_addr

// >>> hdl/frc_core.sv
`timescale 1ns/10ps
`include "frc_map.svh"
//
// Contract
// - Three-bit impedance code 000..111 selects a fixed driver strength.
// - Wrap enable one gives wrapped reads, zero gives sequential reads.
// - Wrapped reads take length from the two-bit wrap length field.
// - ECC bit zero: single-bit correction; one adds double detect; default one.
// - ECC mode also steers trap and counter recording.
// - Power-down-at-start set enters deep power down after reset, else standby.
// - Deep power down exits to standby on chip select pulse; reset leads to standby only with power-down-at-start clear.
// - Nonvolatile and volatile copies writable; volatile start bit read-only.
// - Wrap length 00/01/10/11 gives 8/16/32/64 bytes; default 00.
// - Wrapped read stays within aligned group, wrapping to group start.
module frc_core (
    input wire logic i_ref_clk, // 20 MHz clock
    input wire logic i_rstn, // Sync reset, low active
    input wire logic [3:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic i_cs_n, // Chip select pin, low active
    input wire logic i_rd_start, // Read burst start
    input wire logic [31:0] i_rd_addr, // Burst start address
    input wire logic i_rd_step, // Advance one byte
    output logic [7:0] o_rdata, // Read data
    output logic [7:0] o_drive_strength, // One-hot strength select
    output logic o_ecc_dbl_detect, // Double-bit detect on
    output logic o_ecc_log_dbl, // Trap/counter log double errors
    output logic o_deep_power_down, // In deep power down
    output logic [31:0] o_rd_addr, // Current array address
    output logic [6:0] o_wrap_bytes // Active wrap group size
);
    // ----------------------------------------
    // Bus capture
    // ----------------------------------------
    frc_pkg::frc_bus_type bus;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    logic [7:0] nv_r;
    logic [7:0] v_r;
    frc_pkg::frc_state_type state_r;
    frc_pkg::frc_cfg_type cfg;
    logic cs_meta_r;
    logic cs_sync_r;
    logic cs_prev_r;
    logic cs_pulse;
    logic [31:0] next_addr;
    logic [6:0] len_bytes;

    // Volatile copy drives configuration; power-down-at-start is read from the nonvolatile one
    assign cfg = '{impedance: v_r[`FRC_IMP_HI:`FRC_IMP_LO], wrap_en: v_r[`FRC_WEN_BIT],
                   ecc_dbl: v_r[`FRC_ECC_BIT], wrap_len: v_r[`FRC_WL_HI:`FRC_WL_LO]};

    // ----------------------------------------
    // Nonvolatile copy
    // ----------------------------------------
    // Survives the functional reset; real storage would be array cells
    logic nv_init_r = 1'b0;
    always_ff @(posedge i_ref_clk) begin
        if (!nv_init_r) begin
            nv_r <= `FRC_NV_RESET;
        end else if (bus.wr && bus.addr == `FRC_ADDR_NV) begin
            nv_r <= bus.wdata;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        nv_init_r <= 1'b1;
    end

    // ----------------------------------------
    // Volatile copy
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || state_r == frc_pkg::FRC_ST_LOAD) begin
            v_r <= nv_r;
        end else if (bus.wr && bus.addr == `FRC_ADDR_V) begin
            v_r <= (bus.wdata & `FRC_WRITABLE_V) | (v_r & ~`FRC_WRITABLE_V);
        end
    end

    // ----------------------------------------
    // Chip select sync and pulse detect
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
            cs_prev_r <= 1'b1;
        end else begin
            cs_meta_r <= i_cs_n;
            cs_sync_r <= cs_meta_r;
            cs_prev_r <= cs_sync_r;
        end
    end
    // Rising edge closes a low pulse
    assign cs_pulse = cs_sync_r && !cs_prev_r;

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_r <= frc_pkg::FRC_ST_LOAD;
        end else begin
            unique case (state_r)
                frc_pkg::FRC_ST_LOAD: begin
                    state_r <= nv_r[`FRC_PDS_BIT] ? frc_pkg::FRC_ST_DPD : frc_pkg::FRC_ST_STANDBY;
                end
                frc_pkg::FRC_ST_STANDBY: begin
                    state_r <= frc_pkg::FRC_ST_STANDBY;
                end
                frc_pkg::FRC_ST_DPD: begin
                    if (cs_pulse) begin
                        state_r <= frc_pkg::FRC_ST_STANDBY;
                    end
                end
                default: begin
                    state_r <= frc_pkg::FRC_ST_LOAD;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_deep_power_down <= 1'b0;
        end else begin
            o_deep_power_down <= (state_r == frc_pkg::FRC_ST_DPD && !cs_pulse)
                || (state_r == frc_pkg::FRC_ST_LOAD && nv_r[`FRC_PDS_BIT]);
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_drive_strength <= 8'h01;
            o_ecc_dbl_detect <= 1'b1;
            o_ecc_log_dbl <= 1'b1;
        end else begin
            o_drive_strength <= 8'h01 << cfg.impedance;
            o_ecc_dbl_detect <= cfg.ecc_dbl;
            o_ecc_log_dbl <= cfg.ecc_dbl;
        end
    end

    // ----------------------------------------
    // Read address sequencer
    // ----------------------------------------
    frc_wrap_addr u_wrap (
        .i_addr(o_rd_addr),
        .i_wrap_en(cfg.wrap_en),
        .i_wrap_len(cfg.wrap_len),
        .o_next(next_addr),
        .o_len_bytes(len_bytes)
    );

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rd_addr <= 32'h0000_0000;
        end else if (i_rd_start) begin
            o_rd_addr <= i_rd_addr;
        end else if (i_rd_step && state_r == frc_pkg::FRC_ST_STANDBY) begin
            o_rd_addr <= next_addr;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_wrap_bytes <= 7'h00;
        end else begin
            o_wrap_bytes <= cfg.wrap_en ? len_bytes : 7'h00;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `FRC_ADDR_NV: o_rdata <= nv_r;
                `FRC_ADDR_V: o_rdata <= v_r;
                `FRC_ADDR_STAT: o_rdata <= {5'h00, state_r};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_dpd_entry;
        state_r == frc_pkg::FRC_ST_LOAD && nv_r[`FRC_PDS_BIT];
    endsequence

    a_drive_strength: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $past(i_rstn) |-> o_drive_strength == (8'h01 << $past(v_r[`FRC_IMP_HI:`FRC_IMP_LO])))
        else $error("drive strength mismatch");
    a_wrap_seq: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_rd_step && !i_rd_start && state_r == frc_pkg::FRC_ST_STANDBY && !cfg.wrap_en
        |=> o_rd_addr == $past(o_rd_addr) + 32'h0000_0001)
        else $error("sequential step wrong");
    a_wrap_group: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_rd_step && !i_rd_start && state_r == frc_pkg::FRC_ST_STANDBY && cfg.wrap_en
        |=> o_rd_addr[31:6] == $past(o_rd_addr[31:6]))
        else $error("wrap left group");
    a_wrap_size: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cfg.wrap_en && $stable(cfg.wrap_len) ##1 $past(i_rstn) |-> o_wrap_bytes == (7'h08 << $past(cfg.wrap_len)))
        else $error("wrap size wrong");
    a_ecc_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ##1 $past(i_rstn) |-> o_ecc_dbl_detect == $past(v_r[`FRC_ECC_BIT]) && o_ecc_log_dbl == o_ecc_dbl_detect)
        else $error("ecc mode mismatch");
    a_dpd_start: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_dpd_entry |=> state_r == frc_pkg::FRC_ST_DPD ##0 o_deep_power_down)
        else $error("no deep power down at start");
    a_dpd_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == frc_pkg::FRC_ST_DPD && cs_pulse |=> state_r == frc_pkg::FRC_ST_STANDBY && !o_deep_power_down)
        else $error("deep power down exit failed");
    a_pds_readonly: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r != frc_pkg::FRC_ST_LOAD |=> $stable(v_r[`FRC_PDS_BIT]))
        else $error("volatile start bit changed");
    a_load_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        state_r == frc_pkg::FRC_ST_LOAD |=> v_r == $past(nv_r))
        else $error("volatile copy not loaded");

    // ----------------------------------------
    // Register access, power state, read address and configuration output checks
    // ----------------------------------------
    sequence s_nv_write;
        bus.wr && bus.addr == `FRC_ADDR_NV;
    endsequence

    sequence s_v_write;
        bus.wr && bus.addr == `FRC_ADDR_V && state_r != frc_pkg::FRC_ST_LOAD;
    endsequence

    sequence s_v_read;
        bus.rd && bus.addr == `FRC_ADDR_V;
    endsequence

    sequence s_step_blocked;
        i_rd_step && !i_rd_start && state_r != frc_pkg::FRC_ST_STANDBY;
    endsequence

    sequence s_standby_entry;
        state_r == frc_pkg::FRC_ST_LOAD && !nv_r[`FRC_PDS_BIT];
    endsequence

    sequence s_dpd_idle;
        state_r == frc_pkg::FRC_ST_DPD && !cs_pulse;
    endsequence

    a_nv_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_nv_write |=> nv_r == $past(bus.wdata))
        else $error("nonvolatile write lost");
    // Field by field, so a wrong write mask cannot hide
    a_v_write: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_v_write |=> v_r[`FRC_IMP_HI:`FRC_ECC_BIT] == $past(bus.wdata[`FRC_IMP_HI:`FRC_ECC_BIT])
            && v_r[`FRC_WL_HI:`FRC_WL_LO] == $past(bus.wdata[`FRC_WL_HI:`FRC_WL_LO])
            && v_r[`FRC_PDS_BIT] == $past(v_r[`FRC_PDS_BIT]))
        else $error("volatile write wrong");
    a_v_read: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_v_read |=> o_rdata == $past(v_r))
        else $error("volatile read wrong");
    a_rdata_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !bus.rd |=> o_rdata == 8'h00)
        else $error("read data not cleared");
    a_step_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_step_blocked |=> o_rd_addr == $past(o_rd_addr))
        else $error("step taken outside standby");
    a_standby_start: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_standby_entry |=> state_r == frc_pkg::FRC_ST_STANDBY && !o_deep_power_down)
        else $error("no standby at start");
    a_dpd_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        s_dpd_idle |=> state_r == frc_pkg::FRC_ST_DPD && o_deep_power_down)
        else $error("deep power down left early");
    a_ecc_log: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        ##1 $past(i_rstn) |-> o_ecc_log_dbl == $past(v_r[`FRC_ECC_BIT]))
        else $error("ecc log mode mismatch");
    a_wrap_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !cfg.wrap_en ##1 $past(i_rstn) |-> o_wrap_bytes == 7'h00)
        else $error("wrap size while wrap off");
    a_wrap_len_eight: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cfg.wrap_en && cfg.wrap_len == 2'h0 ##1 $past(i_rstn) |-> o_wrap_bytes == 7'h08)
        else $error("wrap code 0 not 8 bytes");
    a_wrap_len_sixteen: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cfg.wrap_en && cfg.wrap_len == 2'h1 ##1 $past(i_rstn) |-> o_wrap_bytes == 7'h10)
        else $error("wrap code 1 not 16 bytes");
    a_wrap_len_thirtytwo: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cfg.wrap_en && cfg.wrap_len == 2'h2 ##1 $past(i_rstn) |-> o_wrap_bytes == 7'h20)
        else $error("wrap code 2 not 32 bytes");
    a_wrap_len_sixtyfour: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        cfg.wrap_en && cfg.wrap_len == 2'h3 ##1 $past(i_rstn) |-> o_wrap_bytes == 7'h40)
        else $error("wrap code 3 not 64 bytes");
    a_drive_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $onehot(o_drive_strength))
        else $error("drive strength not one-hot");
    a_state_onehot: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $onehot(state_r))
        else $error("power state not one-hot");
endmodule : frc_core

// >>> tb/frc_host_model.sv
`timescale 1ns/10ps
module frc_host_model (
    input wire logic i_ref_clk, // Clock
    input wire logic i_ecc_dbl, // Device ECC mode
    output logic o_cs_n, // Chip select, low active
    output logic o_rd_start, // Burst start
    output logic [31:0] o_rd_addr, // Burst address
    output logic o_rd_step, // Next byte
    output logic o_reprog_r // Array rewrite owed
);
    logic ecc_r;
    initial begin
        o_cs_n = 1'b1;
        o_rd_start = 1'b0;
        o_rd_addr = 32'h0000_0000;
        o_rd_step = 1'b0;
        o_reprog_r = 1'b0;
        ecc_r = 1'b1;
    end
    // Stale check bits until erase and reprogram
    always @(posedge i_ref_clk) begin
        ecc_r <= i_ecc_dbl;
        if (ecc_r != i_ecc_dbl) o_reprog_r <= 1'b1;
    end
    task automatic cs_pulse();
        @(posedge i_ref_clk) o_cs_n <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        o_cs_n <= 1'b1;
    endtask : cs_pulse
    task automatic start(input logic [31:0] a);
        @(posedge i_ref_clk) o_rd_start <= 1'b1;
        o_rd_addr <= a;
        @(posedge i_ref_clk) o_rd_start <= 1'b0;
        o_rd_addr <= ~a;
    endtask : start
    task automatic step();
        @(posedge i_ref_clk) o_rd_step <= 1'b1;
        @(posedge i_ref_clk) o_rd_step <= 1'b0;
    endtask : step
endmodule : frc_host_model

// >>> tb/tb.sv
`timescale 1ns/10ps
`include "frc_map.svh"
module tb;
    typedef struct packed {
        logic [7:0] v;
        logic [7:0] drv;
        logic [6:0] wb;
    } frc_row_type;
    frc_row_type rows [8];
    frc_pkg::frc_bus_type bus;
    logic i_ref_clk;
    logic i_rstn;
    logic cs_n, rd_start, rd_step, ecc, logd, deep_power_down, reprog;
    logic [31:0] rd_addr, addr;
    logic [7:0] rdata, drv;
    logic [6:0] wbytes;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    frc_core i_frc_core (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_addr(bus.addr),
        .i_wdata(bus.wdata),
        .i_wr(bus.wr),
        .i_rd(bus.rd),
        .i_cs_n(cs_n),
        .i_rd_start(rd_start),
        .i_rd_addr(rd_addr),
        .i_rd_step(rd_step),
        .o_rdata(rdata),
        .o_drive_strength(drv),
        .o_ecc_dbl_detect(ecc),
        .o_ecc_log_dbl(logd),
        .o_deep_power_down(deep_power_down),
        .o_rd_addr(addr),
        .o_wrap_bytes(wbytes)
    );
    frc_host_model i_frc_host_model (
        .i_ref_clk(i_ref_clk),
        .i_ecc_dbl(ecc),
        .o_cs_n(cs_n),
        .o_rd_start(rd_start),
        .o_rd_addr(rd_addr),
        .o_rd_step(rd_step),
        .o_reprog_r(reprog)
    );
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_ref_clk) bus <= '0;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_ref_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_ref_clk) bus <= '0;
        @(negedge i_ref_clk) chk(32'(rdata), 32'(e));
    endtask : rd_chk
    task automatic do_reset(input int n);
        @(posedge i_ref_clk) i_rstn <= 1'b0;
        repeat (n) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (3) @(negedge i_ref_clk);
    endtask : do_reset
    task automatic burst(input logic [7:0] c, input logic [31:0] a, input int n, input logic [31:0] e);
        wr(`FRC_ADDR_V, c);
        i_frc_host_model.start(a);
        repeat (n) i_frc_host_model.step();
        @(negedge i_ref_clk) chk(addr, e);
    endtask : burst
    task automatic stop_test();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // ----
    // Sequence
    // ----
    initial begin
        i_rstn = 1'b0;
        bus = '0;
        rows = '{'{8'h08, 8'h01, 7'h00}, '{8'h30, 8'h02, 7'h08}, '{8'h59, 8'h04, 7'h10},
            '{8'h72, 8'h08, 7'h20}, '{8'h9B, 8'h10, 7'h40}, '{8'hA3, 8'h20, 7'h00},
            '{8'hC9, 8'h40, 7'h00}, '{8'hFE, 8'h80, 7'h20}};
        do_reset(12);
        chk(32'({drv, ecc, logd, deep_power_down, wbytes, rdata}), 32'({8'h01, 3'b110, 7'h00, 8'h00}));
        rd_chk(`FRC_ADDR_NV, 8'h08);
        rd_chk(`FRC_ADDR_V, 8'h08);
        rd_chk(`FRC_ADDR_STAT, 8'h02);
        wr(`FRC_ADDR_CTRL, 8'hFF);
        rd_chk(`FRC_ADDR_CTRL, 8'h00);
        rd_chk(`FRC_ADDR_NV, 8'h08);
        foreach (rows[k]) begin
            wr(`FRC_ADDR_V, rows[k].v);
            repeat (2) @(negedge i_ref_clk);
            chk(32'({drv, ecc, logd, wbytes}), 32'({rows[k].drv, rows[k].v[3], rows[k].v[3], rows[k].wb}));
            rd_chk(`FRC_ADDR_V, rows[k].v & 8'hFB);
        end
        chk(32'(reprog), 32'h0000_0001);
        burst(8'h18, 32'h0000_0007, 1, 32'h0000_0000);
        burst(8'h18, 32'h0000_0007, 9, 32'h0000_0000);
        burst(8'h19, 32'h0000_000C, 4, 32'h0000_0000);
        burst(8'h1A, 32'h0000_001E, 2, 32'h0000_0000);
        burst(8'h1B, 32'h1234_56EE, 18, 32'h1234_56C0);
        burst(8'h08, 32'h0000_00FF, 1, 32'h0000_0100);
        wr(`FRC_ADDR_NV, 8'hAC);
        rd_chk(`FRC_ADDR_NV, 8'hAC);
        do_reset(2);
        chk(32'({deep_power_down, drv}), 32'({1'b1, 8'h20}));
        rd_chk(`FRC_ADDR_V, 8'hAC);
        rd_chk(`FRC_ADDR_STAT, 8'h04);
        i_frc_host_model.step();
        @(negedge i_ref_clk) chk(addr, 32'h0000_0000);
        i_frc_host_model.cs_pulse();
        repeat (6) @(negedge i_ref_clk);
        chk(32'(deep_power_down), 32'h0000_0000);
        rd_chk(`FRC_ADDR_STAT, 8'h02);
        // Nonvolatile copy survives reset, so restore it
        wr(`FRC_ADDR_NV, 8'h08);
        do_reset(1);
        chk(32'({deep_power_down, drv}), 32'({1'b0, 8'h01}));
        stop_test();
    end
endmodule : tb
